// file: design/timer_core_pkg.sv
package timer_core_pkg;
  localparam logic [7:0] STATUS_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] COUNTER_HIGH_ADDR   = 8'h04;
  localparam logic [7:0] COUNTER_LOW_ADDR    = 8'h08;
  localparam logic [7:0] MODULO_ADDR         = 8'h0c;
  localparam logic [7:0] DEBUG_CONTROL_ADDR  = 8'h10;

  localparam int OVERFLOW_FLAG_BIT    = 7;
  localparam int OVERFLOW_IRQ_EN_BIT  = 6;
  localparam int CENTER_ALIGN_BIT     = 5;
  localparam int CLOCK_SOURCE_LSB     = 3;
  localparam int PRESCALE_LSB         = 0;

  localparam logic [7:0]  STATUS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET        = 16'h0000;
  localparam logic [15:0] MODULO_RESET         = 16'h0000;
  localparam logic [15:0] COUNT_MAX            = 16'hffff;

  localparam logic [1:0] CLOCK_SOURCE_OFF      = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_BUS      = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_FIXED    = 2'h2;
  localparam logic [1:0] CLOCK_SOURCE_EXTERNAL = 2'h3;

  localparam logic [1:0] AXI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LATCH_IDLE      = 3'b001,
    LATCH_HIGH_READ = 3'b010,
    LATCH_LOW_READ  = 3'b100
  } latch_state_type;
endpackage : timer_core_pkg

// file: design/timer_counter_core_control.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
// What this block does
// - Overflow flag sets when counter wraps to 0x0000 after reaching modulo, or in center-align mode when the down count reaches 0x0000.
// - Flag clears only by reading status while set, then writing zero.
// - Overflow between qualifying read and clearing write restarts the clear sequence.
// - Writing one to flag does nothing; reset clears flag.
// - Interrupt request while flag and enable both one; reset clears enable.
// - Center-align bit selects up/down counting and all-channel center PWM.
// - Clock source field: off, bus clock, fixed clock, external source.
// - External source synchronized here; fixed clock arrives pre-synchronized.
// - Without enabled PLL/FLL, fixed clock choice equals bus clock.
// - Prescale field divides selected clock by two to field value.
// - Prescaler follows clock selection and synchronization.
// - New prescale value acts on the next clock after the update.
// - Reading either counter byte latches both until the other is read.
// - Reset or status/control write restarts counter read latching.
// - Reset clears counter; any counter byte write clears it and latching.
// - Debug mode stops the counter; reads return the frozen count, except a byte latched before debug entry.
// - Debug mode holds latch state even when counter bytes are read.
// - In debug mode, status or counter writes still restart latching.
// - Counting up, counter resumes at zero after modulo; in center-align mode it counts down from modulo; modulo zero means free running.
module timer_counter_core_control
  import timer_core_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        EXTERNAL_CLOCK,
  input  wire logic        FIXED_CLOCK_TICK,
  input  wire logic        PLL_ENABLED,
  output logic             OVERFLOW_IRQ,
  output logic             CENTER_ALIGN,
  output logic [15:0]      COUNT,
  output logic [15:0]      MODULO,
  output logic             COUNT_DOWN
);

  logic [7:0]      status_control;
  logic [15:0]     counter;
  logic [15:0]     modulo_value;
  logic            debug_mode;
  logic            counting_down;
  logic            clear_armed;
  logic [15:0]     latch_buffer;
  latch_state_type latch_state;
  logic [2:0]      ext_sync;
  logic            ext_prev;
  logic [6:0]      prescale_count;
  logic [7:0]      aw_addr;
  logic            aw_held;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            w_held;

  logic overflow_flag;
  logic overflow_irq_enable;
  logic center_align_select;
  logic [1:0] clock_source_select;
  logic [2:0] prescale_select;
  assign overflow_flag       = status_control[OVERFLOW_FLAG_BIT];
  assign overflow_irq_enable = status_control[OVERFLOW_IRQ_EN_BIT];
  assign center_align_select = status_control[CENTER_ALIGN_BIT];
  assign clock_source_select = status_control[CLOCK_SOURCE_LSB +: 2];
  assign prescale_select     = status_control[PRESCALE_LSB +: 3];

  // Write channel: both halves captured independently, executed together
  logic do_write;
  logic wr_status;
  logic wr_counter;
  logic wr_modulo;
  logic wr_debug;
  logic wr_mapped;
  assign do_write   = aw_held && w_held && !BVALID;
  assign wr_status  = do_write && aw_addr == STATUS_CONTROL_ADDR && w_strb[0];
  assign wr_counter = do_write && (aw_addr == COUNTER_HIGH_ADDR || aw_addr == COUNTER_LOW_ADDR);
  assign wr_modulo  = do_write && aw_addr == MODULO_ADDR;
  assign wr_debug   = do_write && aw_addr == DEBUG_CONTROL_ADDR && w_strb[0];
  assign wr_mapped  = aw_addr == STATUS_CONTROL_ADDR || aw_addr == COUNTER_HIGH_ADDR ||
                      aw_addr == COUNTER_LOW_ADDR || aw_addr == MODULO_ADDR ||
                      aw_addr == DEBUG_CONTROL_ADDR;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= AXI_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one request at a time, answer one cycle after address
  logic rd_take;
  logic rd_status;
  logic rd_high;
  logic rd_low;
  assign rd_take   = ARVALID && ARREADY;
  assign rd_status = rd_take && ARADDR == STATUS_CONTROL_ADDR;
  assign rd_high   = rd_take && ARADDR == COUNTER_HIGH_ADDR;
  assign rd_low    = rd_take && ARADDR == COUNTER_LOW_ADDR;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= AXI_RESP_OKAY;
    end else if (rd_take) begin
      RVALID <= 1'b1;
      RRESP  <= AXI_RESP_OKAY;
      unique case (ARADDR)
        STATUS_CONTROL_ADDR: RDATA <= {24'h000000, status_control};
        COUNTER_HIGH_ADDR:   RDATA <= {24'h000000, latch_state == LATCH_LOW_READ ? latch_buffer[15:8] : counter[15:8]};
        COUNTER_LOW_ADDR:    RDATA <= {24'h000000, latch_state == LATCH_HIGH_READ ? latch_buffer[7:0] : counter[7:0]};
        MODULO_ADDR:         RDATA <= {16'h0000, modulo_value};
        DEBUG_CONTROL_ADDR:  RDATA <= {31'h00000000, debug_mode};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= AXI_RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Ready flags are registers so no top-level output is a gate after a flop
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b1;
      WREADY  <= 1'b1;
      ARREADY <= 1'b1;
    end else begin
      if (AWVALID && AWREADY) begin
        AWREADY <= 1'b0;
      end else if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
      end
      if (WVALID && WREADY) begin
        WREADY <= 1'b0;
      end else if (BVALID && BREADY) begin
        WREADY <= 1'b1;
      end
      if (rd_take) begin
        ARREADY <= 1'b0;
      end else if (RVALID && RREADY) begin
        ARREADY <= 1'b1;
      end
    end
  end

  // External source: three stages, edge counts once stages two and three agree
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ext_sync <= 3'h0;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], EXTERNAL_CLOCK};
      if (ext_sync[2] == ext_sync[1]) begin
        ext_prev <= ext_sync[2];
      end
    end
  end

  logic source_tick;
  always_comb begin
    unique case (clock_source_select)
      CLOCK_SOURCE_OFF:      source_tick = 1'b0;
      CLOCK_SOURCE_BUS:      source_tick = 1'b1;
      CLOCK_SOURCE_FIXED:    source_tick = PLL_ENABLED ? FIXED_CLOCK_TICK : 1'b1;
      CLOCK_SOURCE_EXTERNAL: source_tick = ext_sync[2] && ext_sync[1] && !ext_prev;
    endcase
  end

  // Prescaler sees the synchronized, selected tick; field is used live
  logic [6:0] prescale_mask;
  logic       counter_tick;
  assign prescale_mask = 7'((8'h01 << prescale_select) - 8'h01);
  assign counter_tick  = source_tick && !debug_mode && ((prescale_count & prescale_mask) == prescale_mask);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      prescale_count <= 7'h00;
    end else if (source_tick && !debug_mode) begin
      prescale_count <= prescale_count + 7'h01;
    end
  end

  // Counter; effective top is COUNT_MAX when modulo is zero
  logic [15:0] top;
  logic        wrap;
  assign top  = (modulo_value == MODULO_RESET) ? COUNT_MAX : modulo_value;
  assign wrap = counter_tick && !center_align_select && counter >= top;
  logic down_wrap;
  assign down_wrap = counter_tick && center_align_select && counting_down && counter <= 16'h0001;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      counter       <= COUNTER_RESET;
      counting_down <= 1'b0;
    end else if (wr_counter) begin
      counter       <= COUNTER_RESET;
      counting_down <= 1'b0;
    end else if (counter_tick) begin
      if (!center_align_select) begin
        counter       <= wrap ? COUNTER_RESET : counter + 16'h0001;
        counting_down <= 1'b0;
      end else if (!counting_down) begin
        if (counter >= top) begin
          counting_down <= 1'b1;
          counter       <= counter - 16'h0001;
        end else begin
          counter <= counter + 16'h0001;
        end
      end else begin
        if (counter <= 16'h0001) begin
          counting_down <= 1'b0;
        end
        counter <= (counter == COUNTER_RESET) ? COUNTER_RESET : counter - 16'h0001;
      end
    end
  end

  logic overflow_event;
  assign overflow_event = wrap || down_wrap;

  // Status/control and the overflow clear sequence
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      status_control <= STATUS_CONTROL_RESET;
      clear_armed    <= 1'b0;
      modulo_value   <= MODULO_RESET;
      debug_mode     <= 1'b0;
    end else begin
      if (wr_status) begin
        status_control[6:0] <= w_data[6:0];
      end
      if (wr_modulo) begin
        if (w_strb[0]) modulo_value[7:0]  <= w_data[7:0];
        if (w_strb[1]) modulo_value[15:8] <= w_data[15:8];
      end
      if (wr_debug) begin
        debug_mode <= w_data[0];
      end
      if (overflow_event) begin
        status_control[OVERFLOW_FLAG_BIT] <= 1'b1;
        clear_armed <= 1'b0;
      end else if (wr_status && !w_data[OVERFLOW_FLAG_BIT] && clear_armed) begin
        status_control[OVERFLOW_FLAG_BIT] <= 1'b0;
        clear_armed <= 1'b0;
      end else if (rd_status && overflow_flag) begin
        clear_armed <= 1'b1;
      end
    end
  end

  // Byte-read coherency
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      latch_state  <= LATCH_IDLE;
      latch_buffer <= COUNTER_RESET;
    end else if (wr_status || wr_counter) begin
      latch_state <= LATCH_IDLE;
    end else if (!debug_mode) begin
      unique case (latch_state)
        LATCH_IDLE: begin
          if (rd_high) begin
            latch_state  <= LATCH_HIGH_READ;
            latch_buffer <= counter;
          end else if (rd_low) begin
            latch_state  <= LATCH_LOW_READ;
            latch_buffer <= counter;
          end
        end
        LATCH_HIGH_READ: if (rd_low) latch_state <= LATCH_IDLE;
        LATCH_LOW_READ:  if (rd_high) latch_state <= LATCH_IDLE;
        default:         latch_state <= LATCH_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      OVERFLOW_IRQ <= 1'b0;
      CENTER_ALIGN <= 1'b0;
      COUNT        <= COUNTER_RESET;
      MODULO       <= MODULO_RESET;
      COUNT_DOWN   <= 1'b0;
    end else begin
      OVERFLOW_IRQ <= overflow_flag && overflow_irq_enable;
      CENTER_ALIGN <= center_align_select;
      COUNT        <= counter;
      MODULO       <= modulo_value;
      COUNT_DOWN   <= counting_down;
    end
  end

  flag_irq_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (overflow_flag && overflow_irq_enable) |=> OVERFLOW_IRQ)
    else $error("Interrupt not raised for enabled flag");
  wrap_sets_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    overflow_event |=> overflow_flag)
    else $error("Overflow did not set flag");
  unarmed_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (overflow_flag && !clear_armed) |=> overflow_flag)
    else $error("Flag cleared without qualifying read");
  one_write_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_status && w_data[OVERFLOW_FLAG_BIT] && !overflow_flag && !overflow_event) |=> !overflow_flag)
    else $error("Writing one changed flag");
  debug_freeze_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (debug_mode && !wr_counter) |=> counter == $past(counter))
    else $error("Counter moved in debug mode");
  latch_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (debug_mode && !wr_status && !wr_counter) |=> $stable(latch_state))
    else $error("Latch changed in debug mode");
  write_restart_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (wr_status || wr_counter) |=> latch_state == LATCH_IDLE)
    else $error("Latch not restarted by write");
  counter_clear_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    wr_counter |=> counter == COUNTER_RESET)
    else $error("Counter write did not clear");
  off_stop_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (clock_source_select == CLOCK_SOURCE_OFF && !wr_counter) |=> $stable(counter))
    else $error("Counter moved with clock off");
  coherent_read_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (rd_high && latch_state == LATCH_IDLE && !debug_mode && !wr_status && !wr_counter)
      |=> latch_state == LATCH_HIGH_READ && latch_buffer == $past(counter))
    else $error("High read did not latch counter");

  // Clear sequence steps: the qualifying read, then the zero write
  sequence flag_armed_s;
    rd_status && overflow_flag && !overflow_event && !wr_status;
  endsequence
  sequence clean_clear_s;
    wr_status && !w_data[OVERFLOW_FLAG_BIT] && clear_armed && !overflow_event;
  endsequence
  arm_read_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    flag_armed_s |=> clear_armed)
    else $error("Qualifying read did not arm clear");
  clear_flag_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    clean_clear_s |=> !overflow_flag)
    else $error("Qualified clear did not clear flag");
  race_keep_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (overflow_event && clear_armed) |=> overflow_flag && !clear_armed)
    else $error("Overflow during clear sequence was lost");

endmodule : timer_counter_core_control

// file: dv/timer_counter_core_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module timer_counter_core_control_bench;
  import timer_core_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RSTN = 1'b0;
  logic [7:0]  AWADDR = 8'h00;
  logic        AWVALID = 1'b0;
  logic [31:0] WDATA = 32'h0;
  logic        WVALID = 1'b0;
  logic        BREADY = 1'b1;
  logic [7:0]  ARADDR = 8'h00;
  logic        ARVALID = 1'b0;
  logic        RREADY = 1'b1;
  logic        EXTERNAL_CLOCK = 1'b0;
  logic        FIXED_CLOCK_TICK = 1'b0;
  logic        PLL_ENABLED = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, OVERFLOW_IRQ, CENTER_ALIGN, COUNT_DOWN;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA;
  logic [15:0] COUNT, MODULO;
  int          n_errors = 0, checks = 0, n_cyc = 0, n_fix = 0, n_ext = 0;
  int          seed = 32'hfcd20d49;
  logic [2:0]  ext_div = 3'h0;
  logic [7:0]  model_sc = 8'h00;
  logic        armed = 1'b0;
  logic [31:0] d;
  logic [1:0]  r, br;
  logic [15:0] c, f, lo, hi;
  logic        seen_dn;
  logic [7:0]  sc_t [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'h10, 8'h10, 8'h18, 8'h19, 8'h00};
  int          kd_t [11] = '{0, 0, 0, 0, 0, 0, 1, 0, 2, 2, 3};
  int          pl_t [11] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0};

  timer_counter_core_control dut (.CLOCK(CLOCK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .EXTERNAL_CLOCK(EXTERNAL_CLOCK),
    .FIXED_CLOCK_TICK(FIXED_CLOCK_TICK), .PLL_ENABLED(PLL_ENABLED), .OVERFLOW_IRQ(OVERFLOW_IRQ),
    .CENTER_ALIGN(CENTER_ALIGN), .COUNT(COUNT), .MODULO(MODULO), .COUNT_DOWN(COUNT_DOWN));

  always #20 CLOCK = ~CLOCK;

  // External source at one eighth of the bus rate, inside the quarter-rate limit
  always @(posedge CLOCK) begin
    n_cyc <= n_cyc + 1;
    if (FIXED_CLOCK_TICK) n_fix <= n_fix + 1;
    FIXED_CLOCK_TICK <= ($random(seed) & 3) == 0;
    ext_div <= ext_div + 3'h1;
    EXTERNAL_CLOCK <= ext_div[2];
    if (ext_div == 3'h4) n_ext <= n_ext + 1;
  end

  task automatic final_report;
    $display("Counts: %0d comparisons, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic hang;
    n_errors++;
    $display("MISMATCH bus response expected within bound seen none");
    final_report();
  endtask : hang

  // Sample at the falling edge so ready flags are settled, release after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int   n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!bh && n < 100) begin
      @(negedge CLOCK);
      ah = AWVALID && AWREADY;
      wh = WVALID && WREADY;
      bh = BVALID;
      br = BRESP;
      @(posedge CLOCK);
      if (ah) AWVALID <= 1'b0;
      if (wh) WVALID <= 1'b0;
      n++;
    end
    if (!bh) hang();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int   n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    while (!rh && n < 100) begin
      @(negedge CLOCK);
      ah = ARVALID && ARREADY;
      rh = RVALID;
      dv = RDATA;
      rv = RRESP;
      @(posedge CLOCK);
      if (ah) ARVALID <= 1'b0;
      n++;
    end
    if (!rh) hang();
  endtask : rd

  // Status model: a read with the flag set arms; a write of zero to the flag then clears it
  task automatic sc_wr(input logic [7:0] v);
    wr(STATUS_CONTROL_ADDR, {24'h0, v});
    model_sc = {model_sc[7] && !(armed && !v[7]), v[6:0]};
    armed = 1'b0;
  endtask : sc_wr

  task automatic sc_rd;
    rd(STATUS_CONTROL_ADDR, d, r);
    `CHK("status", {24'h0, model_sc}, d)
    armed = model_sc[7];
  endtask : sc_rd

  task automatic ovf;
    model_sc[7] = 1'b1;
    armed = 1'b0;
  endtask : ovf

  function automatic int pick(input int k);
    return (k == 0) ? n_cyc : (k == 1) ? n_fix : (k == 2) ? n_ext : 0;
  endfunction : pick

  task automatic measure(input logic [7:0] sc, input int k);
    int s, e, ex;
    wr(STATUS_CONTROL_ADDR, 32'h0);
    wr(COUNTER_LOW_ADDR, $random(seed));
    s = pick(k);
    wr(STATUS_CONTROL_ADDR, {24'h0, sc});
    repeat (64) @(posedge CLOCK);
    wr(STATUS_CONTROL_ADDR, 32'h0);
    e = pick(k);
    ex = (e - s) >> sc[2:0];
    repeat (3) @(posedge CLOCK);
    `CHK("window count", 1'b1, (COUNT + 16'd3 >= ex) && (COUNT <= ex + 3))
  endtask : measure

  initial begin
    repeat (5) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    sc_rd();
    rd(COUNTER_LOW_ADDR, d, r);
    `CHK("count reset", 32'h0, d)
    rd(8'h1c, d, r);
    `CHK("unmapped resp", AXI_RESP_SLVERR, r)
    wr(8'h1c, 32'h0);
    `CHK("unmapped wresp", AXI_RESP_SLVERR, br)
    $display("Test reset values done");
    wr(MODULO_ADDR, 32'h3);
    `CHK("write resp", AXI_RESP_OKAY, br)
    sc_wr(8'h08);
    repeat (20) @(posedge CLOCK);
    ovf();
    sc_wr(8'h00);
    sc_rd();
    sc_wr(8'hc0);
    sc_rd();
    repeat (2) @(posedge CLOCK);
    `CHK("irq raised", 1'b1, OVERFLOW_IRQ)
    sc_wr(8'h40);
    sc_rd();
    sc_wr(8'hc0);
    sc_rd();
    repeat (2) @(posedge CLOCK);
    `CHK("irq cleared", 1'b0, OVERFLOW_IRQ)
    sc_wr(8'h08);
    repeat (20) @(posedge CLOCK);
    ovf();
    sc_rd();
    repeat (8) @(posedge CLOCK);
    ovf();
    sc_wr(8'h00);
    sc_rd();
    $display("Test overflow flag done");
    wr(MODULO_ADDR, 32'h0);
    for (int i = 0; i < 11; i++) begin
      PLL_ENABLED <= pl_t[i][0];
      measure(sc_t[i], kd_t[i]);
    end
    $display("Test clock source and prescale done");
    wr(STATUS_CONTROL_ADDR, 32'h08);
    repeat (30) @(posedge CLOCK);
    wr(STATUS_CONTROL_ADDR, 32'h0);
    `CHK("count moved", 1'b1, COUNT != 16'h0)
    wr(COUNTER_HIGH_ADDR, $random(seed));
    repeat (2) @(posedge CLOCK);
    `CHK("count cleared", 16'h0, COUNT)
    $display("Test counter clear done");
    wr(STATUS_CONTROL_ADDR, 32'h08);
    repeat (10) @(posedge CLOCK);
    rd(COUNTER_HIGH_ADDR, d, r);
    @(negedge CLOCK);
    c = COUNT;
    @(posedge CLOCK);
    wr(DEBUG_CONTROL_ADDR, 32'h1);
    @(negedge CLOCK);
    f = COUNT;
    repeat (20) @(posedge CLOCK);
    `CHK("frozen count", f, COUNT)
    rd(COUNTER_LOW_ADDR, d, r);
    rd(COUNTER_HIGH_ADDR, d, r);
    `CHK("frozen high", {24'h0, f[15:8]}, d)
    wr(DEBUG_CONTROL_ADDR, 32'h0);
    repeat (20) @(posedge CLOCK);
    rd(COUNTER_LOW_ADDR, d, r);
    `CHK("latched low", 1'b1, (d[7:0] + 16'd4 >= c[7:0]) && (d[7:0] <= c[7:0] + 16'd4))
    rd(COUNTER_HIGH_ADDR, d, r);
    @(negedge CLOCK);
    c = COUNT;
    @(posedge CLOCK);
    wr(DEBUG_CONTROL_ADDR, 32'h1);
    wr(STATUS_CONTROL_ADDR, 32'h08);
    wr(DEBUG_CONTROL_ADDR, 32'h0);
    repeat (30) @(posedge CLOCK);
    rd(COUNTER_LOW_ADDR, d, r);
    `CHK("live low", 1'b1, d[7:0] > c[7:0] + 16'd15)
    $display("Test debug freeze done");
    wr(STATUS_CONTROL_ADDR, 32'h0);
    wr(COUNTER_LOW_ADDR, $random(seed));
    wr(MODULO_ADDR, 32'h5);
    wr(STATUS_CONTROL_ADDR, 32'h28);
    lo = 16'hffff;
    hi = 16'h0;
    seen_dn = 1'b0;
    repeat (40) begin
      @(negedge CLOCK);
      if (COUNT < lo) lo = COUNT;
      if (COUNT > hi) hi = COUNT;
      if (COUNT_DOWN === 1'b1) seen_dn = 1'b1;
    end
    `CHK("center select", 1'b1, CENTER_ALIGN)
    `CHK("count top", 16'h5, hi)
    `CHK("count bottom", 16'h0, lo)
    `CHK("down phase", 1'b1, seen_dn)
    `CHK("modulo out", 16'h5, MODULO)
    $display("Test center count done");
    final_report();
  end
endmodule : timer_counter_core_control_bench
